// ==== ppr_pkg.sv ====
`default_nettype none

package ppr_pkg;

   // ************************************
   // operating modes
   // ************************************
   typedef enum logic [2:0] {
      PPR_MODE_STD    = 3'b000,
      PPR_MODE_BIDI   = 3'b001,
      PPR_MODE_FIFO   = 3'b010,
      PPR_MODE_ECP    = 3'b011,
      PPR_MODE_EPP    = 3'b100,
      PPR_MODE_RSVD   = 3'b101,
      PPR_MODE_TEST   = 3'b110,
      PPR_MODE_CONFIG = 3'b111
   } ppr_mode_t;

   // ************************************
   // register offsets (address lines 2..0)
   // ************************************
   localparam logic [2:0] PPR_OFF_DATA = 3'h0;
   localparam logic [2:0] PPR_OFF_STATUS = 3'h1;
   localparam logic [2:0] PPR_OFF_CONTROL = 3'h2;
   localparam logic [2:0] PPR_OFF_EPP_ADDR = 3'h3;
   localparam logic [2:0] PPR_OFF_EPP_DATA_LO = 3'h4;
   localparam logic [2:0] PPR_OFF_CONFIG_A = 3'h0;
   localparam logic [2:0] PPR_OFF_CONFIG_B = 3'h1;
   localparam logic [2:0] PPR_OFF_EXT_CTRL = 3'h2;

   // ************************************
   // field positions
   // ************************************
   localparam int PPR_STS_BUSY = 7;
   localparam int PPR_STS_TIMEOUT = 0;
   localparam int PPR_CTL_DIR = 5;
   localparam int PPR_CTL_ACK_IRQ_EN = 4;
   localparam int PPR_CTL_SELECT_IN = 3;
   localparam int PPR_CTL_INIT = 2;
   localparam int PPR_CTL_AUTO_FEED = 1;
   localparam int PPR_CTL_STROBE = 0;

   // ************************************
   // reset and fixed values
   // ************************************
   localparam logic [7:0] PPR_CONTROL_RESET = 8'h00_C0;
   localparam logic [2:0] PPR_EXT_CTRL_LOW_RESET = 3'h1;
   localparam logic [7:0] PPR_CONFIG_A_VALUE = 8'h00_1F;
   localparam logic [5:0] PPR_CONFIG_B_LOW = 6'h0_B;
   localparam logic [7:0] PPR_READ_ZERO = 8'h00_00;

   // ************************************
   // timing
   // ************************************
   localparam int PPR_CLK_PERIOD_PS = 4000;
   localparam int PPR_EPP_TIMEOUT_US = 10;
   localparam int PPR_EPP_TIMEOUT_CYCLES = (PPR_EPP_TIMEOUT_US * 1000000) / PPR_CLK_PERIOD_PS;

   // ************************************
   // fifo shape
   // ************************************
   localparam int PPR_FIFO_DEPTH = 16;
   localparam int PPR_FIFO_WIDTH = 9;

endpackage : ppr_pkg

`default_nettype wire

// ==== ppr_port_regs.sv ====
`default_nettype none

// ************************************
// tagged data fifo
// ************************************
module ppr_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic flush_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   // state
   output logic full_o,
   output logic empty_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic push;
   logic pop;

   // full and empty come straight from the count, so they never lie
   assign full_o = (count_reg == (AW + 1)'(DEPTH));
   assign empty_o = (count_reg == '0);
   assign in_ready_o = !full_o;
   assign out_valid_o = !empty_o;
   assign out_data_o = mem[rd_ptr_reg];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // storage, no reset needed on data
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data_i;
      end
   end

   // pointers and count
   always_ff @(posedge clk_i) begin
      if (reset_i || flush_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule : ppr_fifo

// ************************************
// register interface top
// ************************************
module ppr_port_regs (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // host byte bus
   input wire logic primary_port_select_i,
   input wire logic extended_port_select_i,
   input wire logic [2:0] addr_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   // parallel data lines
   input wire logic [7:0] pd_i,
   output logic [7:0] pd_o,
   output logic pd_oe_n_o,
   // peripheral status inputs
   input wire logic busy_i,
   input wire logic ack_i,
   input wire logic paper_error_input_i,
   input wire logic selected_i,
   input wire logic fault_i,
   // peripheral control outputs, high means active
   output logic strobe_o,
   output logic auto_feed_output_o,
   output logic init_o,
   output logic select_in_output_o,
   // host interrupt from acknowledge
   output logic ack_irq_o,
   // epp strobe requests to the handshake sequencer
   input wire logic epp_timeout_enable_i,
   input wire logic epp_cycle_done_i,
   output logic epp_addr_strobe_o,
   output logic epp_data_strobe_o,
   output logic epp_write_o,
   // fifo drain toward the protocol sequencer
   output logic fifo_out_valid_o,
   input wire logic fifo_out_ready_i,
   output logic [7:0] fifo_out_data_o,
   output logic fifo_out_is_address_o,
   // operating mode for the sequencer
   output logic [2:0] mode_o
);

   // ************************************
   // input synchronisers
   // ************************************
   logic [12:0] pin_meta_reg;
   logic [12:0] pin_sync_reg;
   logic [7:0] pd_sync;
   logic busy_sync;
   logic ack_sync;
   logic paper_sync;
   logic selected_sync;
   logic fault_sync;
   logic ack_prev_reg;
   logic ack_rise;

   // two flops on every pin before any logic looks at it
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
      end else begin
         pin_meta_reg <= {pd_i, busy_i, ack_i, paper_error_input_i, selected_i, fault_i};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   assign {pd_sync, busy_sync, ack_sync, paper_sync, selected_sync, fault_sync} = pin_sync_reg;

   // acknowledge edge detect on the settled copy
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ack_prev_reg <= 1'b0;
      end else begin
         ack_prev_reg <= ack_sync;
      end
   end

   assign ack_rise = ack_sync && !ack_prev_reg;

   // ************************************
   // address decode
   // ************************************
   ppr_pkg::ppr_mode_t mode_reg;
   logic [2:0] ext_low_reg;
   logic [7:0] control_reg;
   logic [7:0] data_reg;
   logic print_reg;
   logic timeout_reg;
   logic fifo_full;
   logic fifo_empty;
   logic [8:0] fifo_head;
   logic pp_data_sel;
   logic pp_addr_fifo_sel;
   logic pp_status_sel;
   logic pp_control_sel;
   logic pp_epp_addr_sel;
   logic pp_epp_data_sel;
   logic ep_fifo_sel;
   logic ep_cfg_a_sel;
   logic ep_cfg_b_sel;
   logic ep_ext_sel;
   logic is_fifo_mode;
   logic dir_honoured;

   // primary select window
   assign pp_data_sel = primary_port_select_i && addr_i == ppr_pkg::PPR_OFF_DATA
      && (mode_reg == ppr_pkg::PPR_MODE_STD || mode_reg == ppr_pkg::PPR_MODE_BIDI
      || mode_reg == ppr_pkg::PPR_MODE_EPP);
   assign pp_addr_fifo_sel = primary_port_select_i && addr_i == ppr_pkg::PPR_OFF_DATA
      && mode_reg == ppr_pkg::PPR_MODE_ECP;
   assign pp_status_sel = primary_port_select_i && addr_i == ppr_pkg::PPR_OFF_STATUS;
   assign pp_control_sel = primary_port_select_i && addr_i == ppr_pkg::PPR_OFF_CONTROL;
   assign pp_epp_addr_sel = primary_port_select_i && addr_i == ppr_pkg::PPR_OFF_EPP_ADDR
      && mode_reg == ppr_pkg::PPR_MODE_EPP;
   assign pp_epp_data_sel = primary_port_select_i && addr_i >= ppr_pkg::PPR_OFF_EPP_DATA_LO
      && mode_reg == ppr_pkg::PPR_MODE_EPP;

   // extended select window
   assign is_fifo_mode = mode_reg == ppr_pkg::PPR_MODE_ECP
      || mode_reg == ppr_pkg::PPR_MODE_FIFO || mode_reg == ppr_pkg::PPR_MODE_TEST;
   assign ep_fifo_sel = extended_port_select_i && addr_i == ppr_pkg::PPR_OFF_CONFIG_A
      && is_fifo_mode;
   assign ep_cfg_a_sel = extended_port_select_i && addr_i == ppr_pkg::PPR_OFF_CONFIG_A
      && mode_reg == ppr_pkg::PPR_MODE_CONFIG;
   assign ep_cfg_b_sel = extended_port_select_i && addr_i == ppr_pkg::PPR_OFF_CONFIG_B
      && mode_reg == ppr_pkg::PPR_MODE_CONFIG;
   assign ep_ext_sel = extended_port_select_i && addr_i == ppr_pkg::PPR_OFF_EXT_CTRL;

   // direction does not turn the data drivers around in standard and plain fifo modes
   assign dir_honoured = control_reg[ppr_pkg::PPR_CTL_DIR]
      && mode_reg != ppr_pkg::PPR_MODE_STD && mode_reg != ppr_pkg::PPR_MODE_FIFO;

   // ************************************
   // data fifo
   // ************************************
   logic fifo_push;
   logic [8:0] fifo_push_word;
   logic fifo_host_pop;
   logic fifo_flush;

   // address window sets the tag, data windows clear it
   assign fifo_push = wr_i && (ep_fifo_sel || pp_addr_fifo_sel);
   assign fifo_push_word = {pp_addr_fifo_sel, wdata_i};
   // host reads pop in test mode and in reverse ecp or fifo mode
   assign fifo_host_pop = rd_i && ep_fifo_sel
      && (mode_reg == ppr_pkg::PPR_MODE_TEST || control_reg[ppr_pkg::PPR_CTL_DIR]);
   // the negotiation modes hold no fifo data, so leaving for them drops it
   assign fifo_flush = mode_reg == ppr_pkg::PPR_MODE_STD
      || mode_reg == ppr_pkg::PPR_MODE_BIDI;

   ppr_fifo #(
      .WIDTH(ppr_pkg::PPR_FIFO_WIDTH),
      .DEPTH(ppr_pkg::PPR_FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .flush_i(fifo_flush),
      .in_valid_i(fifo_push),
      .in_ready_o(),
      .in_data_i(fifo_push_word),
      .out_valid_o(fifo_out_valid_o),
      .out_ready_i(fifo_out_ready_i || fifo_host_pop),
      .out_data_o(fifo_head),
      .full_o(fifo_full),
      .empty_o(fifo_empty)
   );

   assign fifo_out_data_o = fifo_head[7:0];
   assign fifo_out_is_address_o = fifo_head[8];

   // ************************************
   // control and extended control
   // ************************************
   // control register, reserved high bits come up set
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         control_reg <= ppr_pkg::PPR_CONTROL_RESET;
      end else if (wr_i && pp_control_sel) begin
         control_reg <= wdata_i;
      end
   end

   // mode field; the reserved code is refused and the old mode kept
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         mode_reg <= ppr_pkg::PPR_MODE_STD;
         ext_low_reg <= ppr_pkg::PPR_EXT_CTRL_LOW_RESET;
      end else if (wr_i && ep_ext_sel) begin
         if (wdata_i[7:5] != ppr_pkg::PPR_MODE_RSVD) begin
            mode_reg <= ppr_pkg::ppr_mode_t'(wdata_i[7:5]);
         end
         ext_low_reg <= wdata_i[4:2];
      end
   end

   assign mode_o = mode_reg;

   // ************************************
   // data register and pins
   // ************************************
   // host data writes, including epp port writes, go onto the lines
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         data_reg <= '0;
      end else if (wr_i && (pp_data_sel || pp_epp_addr_sel || pp_epp_data_sel)) begin
         data_reg <= wdata_i;
      end
   end

   // pin outputs registered once more so every output leaves a flop
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pd_o <= '0;
         pd_oe_n_o <= 1'b1;
         strobe_o <= 1'b0;
         auto_feed_output_o <= 1'b0;
         init_o <= 1'b0;
         select_in_output_o <= 1'b0;
      end else begin
         pd_o <= data_reg;
         pd_oe_n_o <= dir_honoured;
         strobe_o <= control_reg[ppr_pkg::PPR_CTL_STROBE];
         auto_feed_output_o <= control_reg[ppr_pkg::PPR_CTL_AUTO_FEED];
         init_o <= !control_reg[ppr_pkg::PPR_CTL_INIT];
         select_in_output_o <= control_reg[ppr_pkg::PPR_CTL_SELECT_IN];
      end
   end

   // ************************************
   // status flags
   // ************************************
   // ack edge wins over a read in the same cycle
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         print_reg <= 1'b1;
      end else if (ack_rise) begin
         print_reg <= 1'b0;
      end else if (rd_i && pp_status_sel) begin
         print_reg <= 1'b1;
      end
   end

   // acknowledge interrupt, one cycle per rising edge
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ack_irq_o <= 1'b0;
      end else begin
         ack_irq_o <= ack_rise && control_reg[ppr_pkg::PPR_CTL_ACK_IRQ_EN];
      end
   end

   // ************************************
   // epp strobe cycles and timeout
   // ************************************
   logic epp_busy_reg;
   logic [11:0] epp_count_reg;
   logic epp_start;
   logic epp_expired;

   assign epp_start = (rd_i || wr_i) && (pp_epp_addr_sel || pp_epp_data_sel);
   assign epp_expired = epp_busy_reg
      && epp_count_reg == 12'(ppr_pkg::PPR_EPP_TIMEOUT_CYCLES - 1);

   // strobe requests, one cycle each
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         epp_addr_strobe_o <= 1'b0;
         epp_data_strobe_o <= 1'b0;
         epp_write_o <= 1'b0;
      end else begin
         epp_addr_strobe_o <= epp_start && pp_epp_addr_sel;
         epp_data_strobe_o <= epp_start && pp_epp_data_sel;
         if (epp_start) begin
            epp_write_o <= wr_i;
         end
      end
   end

   // handshake watchdog; a new access restarts it
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         epp_busy_reg <= 1'b0;
         epp_count_reg <= '0;
      end else if (epp_start) begin
         epp_busy_reg <= 1'b1;
         epp_count_reg <= '0;
      end else if (epp_cycle_done_i || epp_expired) begin
         epp_busy_reg <= 1'b0;
      end else if (epp_busy_reg) begin
         epp_count_reg <= epp_count_reg + 1'b1;
      end
   end

   // expiry wins over a host clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         timeout_reg <= 1'b0;
      end else if (epp_expired && !epp_cycle_done_i && epp_timeout_enable_i
                   && mode_reg == ppr_pkg::PPR_MODE_EPP) begin
         timeout_reg <= 1'b1;
      end else if (wr_i && pp_status_sel) begin
         timeout_reg <= 1'b0;
      end
   end

   // ************************************
   // read data
   // ************************************
   logic [7:0] status_value;
   logic [7:0] read_value;

   // reserved bit 1 is wired low
   assign status_value = {!busy_sync, ack_sync, paper_sync, selected_sync, fault_sync,
      print_reg, 1'b0, timeout_reg};

   // read mux; unmapped and write-only locations read as zero
   always_comb begin
      read_value = ppr_pkg::PPR_READ_ZERO;
      if (pp_data_sel || pp_epp_addr_sel || pp_epp_data_sel) begin
         read_value = pd_sync;
      end else if (pp_status_sel) begin
         read_value = status_value;
      end else if (pp_control_sel) begin
         read_value = control_reg;
      end else if (ep_fifo_sel) begin
         read_value = fifo_head[7:0];
      end else if (ep_cfg_a_sel) begin
         read_value = ppr_pkg::PPR_CONFIG_A_VALUE;
      end else if (ep_cfg_b_sel) begin
         read_value = {1'b0, ack_irq_o, ppr_pkg::PPR_CONFIG_B_LOW};
      end else if (ep_ext_sel) begin
         read_value = {mode_reg, ext_low_reg, fifo_full, fifo_empty};
      end
   end

   // read data is captured on the strobe and held until the next read
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rdata_o <= ppr_pkg::PPR_READ_ZERO;
      end else if (rd_i) begin
         rdata_o <= read_value;
      end
   end

endmodule : ppr_port_regs

`default_nettype wire

// ==== ppr_port_regs_chk.sv ====
`default_nettype none

module ppr_chk (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // host bus
   input wire logic primary_port_select_i,
   input wire logic extended_port_select_i,
   input wire logic [2:0] addr_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] wdata_i,
   input wire logic [7:0] rdata_o,
   // pins and sequencer side
   input wire logic pd_oe_n_o,
   input wire logic strobe_o,
   input wire logic auto_feed_output_o,
   input wire logic init_o,
   input wire logic select_in_output_o,
   input wire logic epp_addr_strobe_o,
   input wire logic epp_data_strobe_o,
   input wire logic fifo_out_valid_o,
   input wire logic fifo_out_ready_i,
   input wire logic [7:0] fifo_out_data_o,
   input wire logic fifo_out_is_address_o,
   input wire logic [2:0] mode_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   logic pw, pa, ew, er;
   // single-select strobes; both selects at once is no legal access
   assign pw = primary_port_select_i & ~extended_port_select_i & wr_i;
   assign pa = primary_port_select_i & ~extended_port_select_i & (wr_i | rd_i);
   assign ew = extended_port_select_i & ~primary_port_select_i & wr_i;
   assign er = extended_port_select_i & ~primary_port_select_i & rd_i;
   // epp mode is left out, though the control pins follow the control register in that mode too
   property p_stb;
      pw && addr_i == 3'h2 && mode_o != 3'h4 |-> ##2 strobe_o == $past(wdata_i[0], 2);
   endproperty
   a_stb: assert property (p_stb) else $error("strobe pin mismatch");
   property p_feed;
      pw && addr_i == 3'h2 && mode_o != 3'h4 |-> ##2
         auto_feed_output_o == $past(wdata_i[1], 2) && init_o == !$past(wdata_i[2], 2);
   endproperty
   a_feed: assert property (p_feed) else $error("feed or init pin mismatch");
   property p_sel;
      pw && addr_i == 3'h2 && mode_o != 3'h4 |-> ##2 select_in_output_o == $past(wdata_i[3], 2);
   endproperty
   a_sel: assert property (p_sel) else $error("select-in pin mismatch");
   property p_oe;
      (mode_o == 3'h0 || mode_o == 3'h2) [*3] |-> !pd_oe_n_o;
   endproperty
   a_oe: assert property (p_oe) else $error("data drivers off in forward-only mode");
   property p_as;
      pa && addr_i == 3'h3 |=> epp_addr_strobe_o == ($past(mode_o) == 3'h4);
   endproperty
   a_as: assert property (p_as) else $error("address strobe request mismatch");
   property p_ds;
      pa && addr_i[2] |=> epp_data_strobe_o == ($past(mode_o) == 3'h4);
   endproperty
   a_ds: assert property (p_ds) else $error("data strobe request mismatch");
   property p_mode;
      ew && addr_i == 3'h2 |=>
         mode_o == (($past(wdata_i[7:5]) == 3'h5) ? $past(mode_o) : $past(wdata_i[7:5]));
   endproperty
   a_mode: assert property (p_mode) else $error("mode field mismatch");
   property p_tag;
      pw && addr_i == 3'h0 && mode_o == 3'h3 && !fifo_out_valid_o && !fifo_out_ready_i |=>
         fifo_out_valid_o && fifo_out_is_address_o && fifo_out_data_o == $past(wdata_i);
   endproperty
   a_tag: assert property (p_tag) else $error("address byte not queued with tag");
   property p_cfga;
      er && addr_i == 3'h0 && mode_o == 3'h7 |=> rdata_o == 8'h1F;
   endproperty
   a_cfga: assert property (p_cfga) else $error("config a value mismatch");
   property p_zero;
      pa && rd_i && addr_i == 3'h1 |=> !rdata_o[1];
   endproperty
   a_zero: assert property (p_zero) else $error("reserved status bit set");
endmodule : ppr_chk

bind ppr_port_regs ppr_chk i_chk (
   .clk_i, .reset_i, .primary_port_select_i, .extended_port_select_i, .addr_i,
   .wr_i, .rd_i, .wdata_i, .rdata_o, .pd_oe_n_o, .strobe_o, .auto_feed_output_o,
   .init_o, .select_in_output_o, .epp_addr_strobe_o, .epp_data_strobe_o,
   .fifo_out_valid_o, .fifo_out_ready_i, .fifo_out_data_o, .fifo_out_is_address_o,
   .mode_o
);

`default_nettype wire

// ==== ppr_periph_model.sv ====
`default_nettype none

module ppr_periph_model (
   // clock
   input wire logic clk_i,
   // host side pins
   input wire logic [7:0] pd_o,
   input wire logic pd_oe_n_o,
   input wire logic strobe_o,
   // bench commands: {busy, paper, selected, fault}, reverse byte, slow answer
   input wire logic [3:0] st_i,
   input wire logic [7:0] rev_i,
   input wire logic slow_i,
   // peripheral pins
   output logic [7:0] pd_i,
   output logic busy_i,
   output logic ack_i,
   output logic paper_error_input_i,
   output logic selected_i,
   output logic fault_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic stb_q = 1'b0;
   int cnt = 0;
   // line level: host drive wins only while its drivers are on
   assign pd_i = pd_oe_n_o ? rev_i : pd_o;
   assign {busy_i, paper_error_input_i, selected_i, fault_i} = st_i;
   // acknowledge pulse of four cycles, late by a prompt or a slow delay
   always @(posedge clk_i) begin
      stb_q <= strobe_o;
      if (strobe_o && !stb_q) begin
         cnt <= slow_i ? 40 : 6;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
      ack_i <= (cnt > 0 && cnt <= 4);
   end
endmodule : ppr_periph_model

`default_nettype wire

// ==== tb.sv ====
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [7:0] e;
      logic [7:0] m;
   } ppr_exp_t;
   logic clk_i = 1'b0;
   logic reset_i, primary_port_select_i, extended_port_select_i, wr_i, rd_i, slow, rd_q;
   logic epp_timeout_enable_i, epp_cycle_done_i, fifo_out_ready_i;
   logic [2:0] addr_i, mode_o, em;
   logic [3:0] st;
   logic [7:0] wdata_i, rdata_o, pd_o, fifo_out_data_o, rev, d, n_irq, fq[16];
   logic [31:0] rnd = 32'h0000_3ecb;
   wire logic [7:0] pd_i;
   wire logic busy_i, ack_i, paper_error_input_i, selected_i, fault_i;
   logic pd_oe_n_o, strobe_o, auto_feed_output_o, init_o, select_in_output_o, ack_irq_o;
   logic epp_addr_strobe_o, epp_data_strobe_o, epp_write_o, fifo_out_valid_o;
   logic fifo_out_is_address_o;
   int fail_count = 0, n_checks = 0, k;
   ppr_exp_t expq[$], x;
   wire logic [7:0] pins = {3'h0, pd_oe_n_o, select_in_output_o, init_o, auto_feed_output_o,
      strobe_o};

   ppr_port_regs i_dut (
      .clk_i, .reset_i, .primary_port_select_i, .extended_port_select_i, .addr_i, .wr_i,
      .rd_i, .wdata_i, .rdata_o, .pd_i, .pd_o, .pd_oe_n_o, .busy_i, .ack_i,
      .paper_error_input_i, .selected_i, .fault_i, .strobe_o, .auto_feed_output_o,
      .init_o, .select_in_output_o, .ack_irq_o, .epp_timeout_enable_i, .epp_cycle_done_i,
      .epp_addr_strobe_o, .epp_data_strobe_o, .epp_write_o, .fifo_out_valid_o,
      .fifo_out_ready_i, .fifo_out_data_o, .fifo_out_is_address_o, .mode_o
   );
   ppr_periph_model i_per (
      .clk_i, .pd_o, .pd_oe_n_o, .strobe_o, .st_i(st), .rev_i(rev), .slow_i(slow),
      .pd_i, .busy_i, .ack_i, .paper_error_input_i, .selected_i, .fault_i
   );

   // 250 MHz
   always #2 clk_i = ~clk_i;

   // ************
   // helpers
   // ************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // one-cycle strobe, held with its address and data until the next falling edge
   task automatic acc(input logic e, input logic [2:0] a, input logic w, input logic [7:0] v);
      @(negedge clk_i);
      primary_port_select_i = !e;
      extended_port_select_i = e;
      addr_i = a;
      wr_i = w;
      rd_i = !w;
      wdata_i = v;
      @(negedge clk_i);
      {primary_port_select_i, extended_port_select_i, wr_i, rd_i} = 4'h0;
   endtask : acc
   task automatic wr(input logic e, input logic [2:0] a, input logic [7:0] v);
      acc(e, a, 1'b1, v);
   endtask : wr
   task automatic rd(input logic e, input logic [2:0] a, input logic [7:0] v, input logic [7:0] m);
      expq.push_back('{v, m});
      acc(e, a, 1'b0, 8'h00);
   endtask : rd
   task automatic pop();
      @(negedge clk_i);
      fifo_out_ready_i = 1'b1;
      @(negedge clk_i);
      fifo_out_ready_i = 1'b0;
   endtask : pop
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : test_done

   // read data is settled one edge after the strobe; oldest note is its match
   always @(posedge clk_i) begin
      if (rd_q) begin
         if (expq.size() == 0) begin
            cmp(rdata_o, 8'hxx);
         end else begin
            x = expq.pop_front();
            cmp(rdata_o & x.m, x.e & x.m);
         end
      end
      rd_q <= rd_i & !reset_i;
   end

   // hang guard
   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      test_done();
   end

   // ************
   // scenarios
   // ************
   initial begin
      {primary_port_select_i, extended_port_select_i, wr_i, rd_i, slow} = 5'h00;
      {epp_timeout_enable_i, epp_cycle_done_i, fifo_out_ready_i} = 3'h0;
      addr_i = 3'h0;
      wdata_i = 8'h00;
      st = 4'h0;
      rev = 8'h00;
      reset_i = 1'b1;
      repeat (12) @(negedge clk_i);
      reset_i = 1'b0;
      rd(1'b0, 3'h2, 8'hC0, 8'hFF);
      rd(1'b1, 3'h2, 8'h05, 8'hFF);
      // random status levels, print bit still set from reset
      for (k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         st = rnd[3:0];
         repeat (4) @(negedge clk_i);
         rd(1'b0, 3'h1, {~st[3], 1'b0, st[2:0], 3'b100}, 8'hFF);
      end
      // random control bytes; direction is ignored in standard mode
      for (k = 0; k < 6; k++) begin
         rnd = lfsr(rnd);
         d = rnd[7:0];
         wr(1'b0, 3'h2, d);
         repeat (2) @(negedge clk_i);
         cmp(pins, {4'h0, d[3], ~d[2], d[1], d[0]});
         rd(1'b0, 3'h2, d, 8'h3F);
      end
      wr(1'b0, 3'h2, 8'h00);
      rnd = lfsr(rnd);
      d = rnd[7:0];
      wr(1'b0, 3'h0, d);
      repeat (2) @(negedge clk_i);
      cmp(pd_o, d);
      repeat (3) @(negedge clk_i);
      rd(1'b0, 3'h0, d, 8'hFF);
      // bidirectional, reversed: the peripheral drives a different byte
      wr(1'b1, 3'h2, 8'h24);
      wr(1'b0, 3'h2, 8'h20);
      rev = ~d;
      repeat (5) @(negedge clk_i);
      cmp(pins, 8'h14);
      rd(1'b0, 3'h0, ~d, 8'hFF);
      wr(1'b0, 3'h2, 8'h00);
      // prompt answer with interrupt off, slow answer with it on
      for (k = 0; k < 2; k++) begin
         slow = k[0];
         wr(1'b0, 3'h2, {3'h0, slow, 4'h1});
         wr(1'b0, 3'h2, {3'h0, slow, 4'h0});
         n_irq = 8'h00;
         repeat (60) begin
            @(negedge clk_i);
            if (ack_irq_o === 1'b1) n_irq++;
         end
         cmp(n_irq, {7'h00, slow});
         rd(1'b0, 3'h1, 8'h00, 8'h04);
         rd(1'b0, 3'h1, 8'h04, 8'h04);
      end
      // every mode code, the reserved one refused
      em = 3'h1;
      for (k = 0; k < 8; k++) begin
         wr(1'b1, 3'h2, {k[2:0], 5'h04});
         if (k != 5) em = k[2:0];
         rd(1'b1, 3'h2, {em, 5'h04}, 8'hFC);
      end
      rd(1'b1, 3'h0, 8'h1F, 8'hFF);
      rd(1'b1, 3'h1, 8'h0B, 8'hFF);
      // capability mode: address then data byte into one queue
      wr(1'b1, 3'h2, 8'h64);
      wr(1'b0, 3'h0, 8'hA5);
      wr(1'b1, 3'h0, 8'h3C);
      cmp({fifo_out_valid_o, fifo_out_is_address_o, 6'h00}, 8'hC0);
      cmp(fifo_out_data_o, 8'hA5);
      pop();
      cmp({fifo_out_valid_o, fifo_out_is_address_o, 6'h00}, 8'h80);
      cmp(fifo_out_data_o, 8'h3C);
      pop();
      rd(1'b1, 3'h2, 8'h65, 8'hFF);
      // fill past full while the sequencer stalls, then drain from the host
      wr(1'b1, 3'h2, 8'h44);
      for (k = 0; k < 17; k++) begin
         rnd = lfsr(rnd);
         if (k < 16) fq[k] = rnd[7:0];
         wr(1'b1, 3'h0, rnd[7:0]);
      end
      rd(1'b1, 3'h2, 8'h46, 8'hFF);
      wr(1'b1, 3'h2, 8'hC4);
      for (k = 0; k < 16; k++) rd(1'b1, 3'h0, fq[k], 8'hFF);
      rd(1'b1, 3'h2, 8'hC5, 8'hFF);
      // epp: every strobe port answered, then one left to time out
      wr(1'b1, 3'h2, 8'h84);
      epp_timeout_enable_i = 1'b1;
      for (k = 3; k < 8; k++) begin
         rnd = lfsr(rnd);
         wr(1'b0, k[2:0], rnd[7:0]);
         epp_cycle_done_i = 1'b1;
         @(negedge clk_i);
         epp_cycle_done_i = 1'b0;
      end
      cmp({7'h00, epp_write_o}, 8'h01);
      rd(1'b0, 3'h1, 8'h00, 8'h01);
      wr(1'b0, 3'h4, 8'h00);
      repeat (2400) @(negedge clk_i);
      rd(1'b0, 3'h1, 8'h00, 8'h01);
      repeat (200) @(negedge clk_i);
      rd(1'b0, 3'h1, 8'h01, 8'h01);
      wr(1'b0, 3'h1, 8'hFF);
      rd(1'b0, 3'h1, 8'h00, 8'h01);
      rd(1'b0, 3'h2, 8'h10, 8'h3F);
      repeat (4) @(negedge clk_i);
      test_done();
   end
endmodule : tb

`default_nettype wire
